// File: hdl/msct_pkg.sv
package msct_pkg;

   // ----------------------------------------------------------------
   // timing figures and derived cycle counts
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ           = 200;
   localparam int unsigned MASK_MS           = 100;   // mask set or clear latency
   localparam int unsigned SEL_US            = 100;   // select assert/deassert latency
   localparam int unsigned PDOWN_ON_MS       = 100;
   localparam int unsigned PDOWN_OFF_MS      = 300;
   localparam int unsigned INT_OFF_US        = 500;
   localparam int unsigned FLAG_ON_MS        = 200;
   localparam int unsigned INIT_MS           = 2000;
   localparam int unsigned RESET_MIN_US      = 2;
   // longest times still fit in 32 bits exactly; all far exceed one cycle
   localparam int unsigned SEL_CYC           = SEL_US * CLK_MHZ;
   localparam int unsigned INT_OFF_CYC       = INT_OFF_US * CLK_MHZ;
   localparam int unsigned PDOWN_OFF_CYC     = PDOWN_OFF_MS * 1000 * CLK_MHZ;
   localparam int unsigned INIT_CYC          = INIT_MS * 1000 * CLK_MHZ;
   localparam int unsigned RESET_MIN_CYC     = RESET_MIN_US * CLK_MHZ;
   // chosen internal latencies, well inside the limits above
   localparam int unsigned SEL_DLY_CYC       = 16;
   localparam int unsigned WAKE_DLY_CYC      = 32;
   localparam int unsigned INIT_DLY_CYC      = 64;

   // ----------------------------------------------------------------
   // status layout
   // ----------------------------------------------------------------
   localparam int unsigned NFLAG             = 8;
   localparam int unsigned NOT_READY_BYTE    = 2;
   localparam int unsigned NOT_READY_BIT     = 0;
   localparam logic [7:0]  MASK_RST          = 8'h00;

   typedef enum logic [1:0] {
      MSCT_PW_INIT,
      MSCT_PW_FULL,
      MSCT_PW_LOW,
      MSCT_PW_WAKE
   } msct_pwr_t;

   // event crossing from link domain to core domain
   typedef struct packed {
      logic       cor_done;   // clear-on-read transaction ended
      logic       wr_done;    // control write ended
   } msct_link_evt_t;

endpackage

// File: hdl/msct_sync.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// two-flop level synchroniser, first flop feeds only the second
// ------------------------------------------------------------------
module msct_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_in,   // destination clock
   input  wire logic [W-1:0] d_in,     // asynchronous level
   output logic      [W-1:0] q_out     // synchronised level
);
   logic [W-1:0] meta;

   // no reset: settles within two edges of clk_in
   always_ff @(posedge clk_in) begin
      meta  <= d_in;
      q_out <= meta;
   end
endmodule // msct_sync

// File: hdl/msct_top.sv
`timescale 1ns/1ps
// Summary of operation
// - setting a mask bit stops interrupt for that flag within 100 ms.
// - clearing a mask bit resumes interrupt for that flag within 100 ms.
// - select asserted low, module answers serial bus within 100 us.
// - select deasserted, module stops answering within 100 us; host waits.
// - power-down or override set, enter low power within 100 ms.
// - power-down cleared, fully functional again within 300 ms.
// - fully functional means not-ready bit cleared and interrupt asserted by it.
// - clear-on-read latency counts from falling clock after read stop.
// - control write latency counts from falling clock after write stop.
// - clear-on-read of causing flag releases interrupt within 500 us.
// - flag condition sets flag and asserts interrupt within 200 ms.
// - within 2000 ms of power-on, clear not-ready and assert interrupt.
module msct_top (
   input  wire logic                       clk_in,           // core clock, 200 MHz
   input  wire logic                       rst_in,           // sync reset, active high
   input  wire logic                       link_clk_in,      // serial bus clock
   input  wire logic                       module_select_n,  // host select pin, low active
   input  wire logic                       module_reset_n,   // host reset pin, low active
   input  wire logic                       low_power_pin,    // host low-power pin
   input  wire logic                       stop_seen_in,     // link: stop condition seen
   input  wire logic                       stop_is_read_in,  // link: ended txn was a read
   input  wire logic                       cor_access_in,    // link: read touched flag bytes
   input  wire logic [7:0]                 mask_wr_in,       // link: mask value written
   input  wire logic                       mask_wr_en_in,    // link: mask byte written
   input  wire logic                       pdown_wr_in,      // link: power-down value written
   input  wire logic                       pdown_wr_en_in,   // link: power-down byte written
   input  wire logic                       override_in,      // link: power override bit
   input  wire logic [msct_pkg::NFLAG-1:0] cond_in,          // raw flag conditions, async
   output logic                            bus_answer_out,   // serial slave may respond
   output logic                            low_power_out,    // lower power level active
   output logic                            not_ready_out,    // data-not-ready status bit
   output logic [msct_pkg::NFLAG-1:0]      flags_out,        // latched flags
   output logic [7:0]                      mask_out,         // applied mask
   output logic                            interrupt_out_n,  // interrupt pin, low active
   output logic                            present_out_n     // present pin, tied active
);
   // ----------------------------------------------------------------
   // link domain: commit writes on falling edge after stop
   // ----------------------------------------------------------------
   logic       stop_pend;
   logic       stop_rd;
   logic       cor_tgl;
   logic       wr_tgl;
   logic [7:0] mask_hold;
   logic       pdown_hold;
   logic       cor_pend;

   // stop is armed on rising link clock, acted on at next falling one
   always_ff @(posedge link_clk_in) begin
      if (!module_reset_n) begin
         stop_pend  <= 1'b0;
         stop_rd    <= 1'b0;
         mask_hold  <= msct_pkg::MASK_RST;
         pdown_hold <= 1'b0;
         cor_pend   <= 1'b0;
      end else begin
         stop_pend <= stop_seen_in;
         stop_rd   <= stop_is_read_in;
         if (mask_wr_en_in) begin
            mask_hold <= mask_wr_in;
         end
         if (pdown_wr_en_in) begin
            pdown_hold <= pdown_wr_in;
         end
         // held through the commit edge, dropped one rising edge later
         if (stop_pend) begin
            cor_pend <= 1'b0;
         end else if (cor_access_in) begin
            cor_pend <= 1'b1;
         end
      end
   end

   logic [7:0] mask_commit;
   logic       pdown_commit;

   // falling edge after stop marks the reference points
   always_ff @(negedge link_clk_in) begin
      if (!module_reset_n) begin
         cor_tgl      <= 1'b0;
         wr_tgl       <= 1'b0;
         mask_commit  <= msct_pkg::MASK_RST;
         pdown_commit <= 1'b0;
      end else if (stop_pend) begin
         if (stop_rd && cor_pend) begin
            cor_tgl <= ~cor_tgl;
         end
         if (!stop_rd) begin
            wr_tgl       <= ~wr_tgl;
            mask_commit  <= mask_hold;
            pdown_commit <= pdown_hold;
         end
      end
   end

   // ----------------------------------------------------------------
   // crossings into core domain
   // ----------------------------------------------------------------
   logic [msct_pkg::NFLAG-1:0] cond_s;
   logic [7:0]                 mask_s;
   logic                       sel_s;
   logic                       rstn_s;
   logic                       lpin_s;
   logic                       pd_s;
   logic                       ovr_s;
   logic                       cor_s;
   logic                       wr_s;

   // mask word is stable before its toggle lands, so sampled on the toggle
   msct_sync #(.W(msct_pkg::NFLAG + 7)) u_sync (
      .clk_in (clk_in),
      .d_in   ({cond_in, module_select_n, module_reset_n, low_power_pin,
                pdown_commit, override_in, cor_tgl, wr_tgl}),
      .q_out  ({cond_s, sel_s, rstn_s, lpin_s, pd_s, ovr_s, cor_s, wr_s})
   );

   // ----------------------------------------------------------------
   // core reset: pin reset or block reset
   // ----------------------------------------------------------------
   logic core_rst;
   assign core_rst = rst_in | ~rstn_s;   // pin width is host's duty

   msct_pkg::msct_link_evt_t evt;
   logic                     cor_d;
   logic                     wr_d;

   // toggle edges become one-cycle events
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cor_d <= 1'b0;
         wr_d  <= 1'b0;
      end else begin
         cor_d <= cor_s;
         wr_d  <= wr_s;
      end
   end
   assign evt.cor_done = cor_s ^ cor_d;
   assign evt.wr_done  = wr_s ^ wr_d;

   // mask captured only on a write event, when the word is settled;
   // pin reset clears it too, or the old mask would return after reset
   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         mask_s <= msct_pkg::MASK_RST;
      end else if (evt.wr_done) begin
         mask_s <= mask_commit;
      end
   end

   // ----------------------------------------------------------------
   // select gating of serial responses
   // ----------------------------------------------------------------
   logic [4:0] sel_cnt;
   logic       sel_want;

   assign sel_want = ~sel_s;

   // small debounce, well inside the 100 us window
   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         sel_cnt        <= '0;
         bus_answer_out <= 1'b0;
      end else if (sel_want == bus_answer_out) begin
         sel_cnt <= '0;
      end else if (sel_cnt == 5'(msct_pkg::SEL_DLY_CYC - 1)) begin
         sel_cnt        <= '0;
         bus_answer_out <= sel_want;
      end else begin
         sel_cnt <= sel_cnt + 5'h01;
      end
   end

   // ----------------------------------------------------------------
   // power state
   // ----------------------------------------------------------------
   msct_pkg::msct_pwr_t pwr;
   logic [6:0]          pwr_cnt;
   logic                low_req;

   assign low_req = pd_s | ovr_s | lpin_s;

   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         pwr     <= msct_pkg::MSCT_PW_INIT;
         pwr_cnt <= '0;
      end else begin
         case (pwr)
            msct_pkg::MSCT_PW_INIT: begin
               pwr_cnt <= pwr_cnt + 7'h01;
               if (pwr_cnt == 7'(msct_pkg::INIT_DLY_CYC - 1)) begin
                  pwr     <= msct_pkg::MSCT_PW_FULL;
                  pwr_cnt <= '0;
               end
            end
            msct_pkg::MSCT_PW_FULL: begin
               if (low_req) begin
                  pwr <= msct_pkg::MSCT_PW_LOW;
               end
            end
            msct_pkg::MSCT_PW_LOW: begin
               if (!low_req) begin
                  pwr     <= msct_pkg::MSCT_PW_WAKE;
                  pwr_cnt <= '0;
               end
            end
            msct_pkg::MSCT_PW_WAKE: begin
               pwr_cnt <= pwr_cnt + 7'h01;
               if (low_req) begin
                  pwr <= msct_pkg::MSCT_PW_LOW;
               end else if (pwr_cnt == 7'(msct_pkg::WAKE_DLY_CYC - 1)) begin
                  pwr     <= msct_pkg::MSCT_PW_FULL;
                  pwr_cnt <= '0;
               end
            end
            default: begin
               pwr <= msct_pkg::MSCT_PW_INIT;
            end
         endcase
      end
   end

   assign low_power_out = (pwr == msct_pkg::MSCT_PW_LOW);

   // ----------------------------------------------------------------
   // not-ready bit: set while initialising or waking
   // ----------------------------------------------------------------
   logic ready_evt;
   logic pwr_full_d;

   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         not_ready_out <= 1'b1;
         pwr_full_d    <= 1'b0;
      end else begin
         pwr_full_d <= (pwr == msct_pkg::MSCT_PW_FULL);
         if (pwr == msct_pkg::MSCT_PW_INIT || pwr == msct_pkg::MSCT_PW_WAKE) begin
            not_ready_out <= 1'b1;
         end else if (pwr == msct_pkg::MSCT_PW_FULL) begin
            not_ready_out <= 1'b0;
         end
      end
   end
   assign ready_evt = (pwr == msct_pkg::MSCT_PW_FULL) & ~pwr_full_d;

   // ----------------------------------------------------------------
   // flags, ready latch and interrupt
   // ----------------------------------------------------------------
   logic ready_flag;

   // latched flags; a new condition beats a simultaneous clear
   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         flags_out  <= '0;
         ready_flag <= 1'b0;
      end else begin
         flags_out  <= (evt.cor_done ? '0 : flags_out) | cond_s;
         ready_flag <= (evt.cor_done ? 1'b0 : ready_flag) | ready_evt;
      end
   end

   // mask applies the cycle after capture, far within 100 ms
   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         mask_out        <= msct_pkg::MASK_RST;
         interrupt_out_n <= 1'b1;
      end else begin
         mask_out        <= mask_s;
         interrupt_out_n <= ~(|(flags_out & ~mask_out) | ready_flag);
      end
   end

   assign present_out_n = 1'b0;
endmodule // msct_top

// File: dv/msct_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port-level checks on the control and status block
// ----------------------------------------------------------------
module msct_asserts (
   input wire logic                       clk_in,          // core clock
   input wire logic                       rst_in,          // sync reset
   input wire logic                       module_select_n, // select pin
   input wire logic                       module_reset_n,  // reset pin
   input wire logic                       low_power_pin,   // low-power pin
   input wire logic [msct_pkg::NFLAG-1:0] cond_in,         // raw conditions
   input wire logic                       bus_answer_out,  // answer enable
   input wire logic                       low_power_out,   // low power level
   input wire logic                       not_ready_out,   // not-ready bit
   input wire logic [msct_pkg::NFLAG-1:0] flags_out,       // latched flags
   input wire logic [7:0]                 mask_out,        // applied mask
   input wire logic                       interrupt_out_n  // interrupt pin
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // bounds are loose on purpose: syncs add a cycle or two
   property p_ready_int; $fell(not_ready_out) |-> ##[0:2] !interrupt_out_n; endproperty
   a_ready_int: assert property (p_ready_int)
      else $error("ready did not assert interrupt");
   property p_sel_on; $fell(module_select_n) |-> ##[1:30] bus_answer_out; endproperty
   a_sel_on: assert property (p_sel_on)
      else $error("select did not enable answering");
   property p_sel_off; $rose(module_select_n) |-> ##[1:30] !bus_answer_out; endproperty
   a_sel_off: assert property (p_sel_off)
      else $error("deselect did not stop answering");
   property p_lp_on; $rose(low_power_pin) |-> ##[1:10] low_power_out; endproperty
   a_lp_on: assert property (p_lp_on)
      else $error("low power not entered");
   property p_wake; $fell(low_power_out) |-> ##[1:60] !not_ready_out; endproperty
   a_wake: assert property (p_wake)
      else $error("wake did not reach ready");
   property p_flag_set; $rose(cond_in[0]) |-> ##[1:6] flags_out[0]; endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("flag not set by condition");
   property p_unmasked; (|(flags_out & ~mask_out))[*3] |-> !interrupt_out_n; endproperty
   a_unmasked: assert property (p_unmasked)
      else $error("unmasked flag without interrupt");
   property p_mreset;
      $fell(module_reset_n) |-> ##[2:4] (interrupt_out_n && not_ready_out && mask_out == 8'h00);
   endproperty
   a_mreset: assert property (p_mreset)
      else $error("reset pin did not reset state");
endmodule // msct_asserts

bind msct_top msct_asserts chk_u (.clk_in, .rst_in, .module_select_n, .module_reset_n,
   .low_power_pin, .cond_in, .bus_answer_out, .low_power_out, .not_ready_out, .flags_out,
   .mask_out, .interrupt_out_n);

// File: dv/msct_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host controller: link events, link clock runs only in frames or direct tick calls
// ----------------------------------------------------------------
module msct_host_model (
   output logic       link_clk_out     = 1'b0, // stands low between frames
   output logic       stop_seen_out    = 1'b0, // stop condition
   output logic       stop_is_read_out = 1'b0, // ended transfer was a read
   output logic       cor_access_out   = 1'b0, // read touched flag bytes
   output logic [7:0] mask_wr_out      = 8'h00, // mask byte
   output logic       mask_wr_en_out   = 1'b0, // mask byte written
   output logic       pdown_wr_out     = 1'b0, // power-down bit
   output logic       pdown_wr_en_out  = 1'b0  // power-down byte written
);
   // 6 ns link period, changes land after the falling edge
   task automatic tick(input int n);
      repeat (n) begin
         #3 link_clk_out = 1'b1;
         #3 link_clk_out = 1'b0;
      end
   endtask
   // kind 0 mask write, 1 power-down write, 2 clear-on-read read
   task automatic frame(input int kind, input logic [7:0] v);
      mask_wr_out     = v;
      pdown_wr_out    = v[0];
      mask_wr_en_out  = (kind == 0);
      pdown_wr_en_out = (kind == 1);
      cor_access_out  = (kind == 2);
      tick(1);
      mask_wr_en_out   = 1'b0;
      pdown_wr_en_out  = 1'b0;
      cor_access_out   = 1'b0;
      stop_seen_out    = 1'b1;
      stop_is_read_out = (kind == 2);
      tick(1);
      stop_seen_out = 1'b0;
      tick(1);
      // data released after commit: no longer shows the held value
      mask_wr_out  = ~v;
      pdown_wr_out = ~v[0];
   endtask
endmodule // msct_host_model

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   typedef struct {logic sel_n, lp, ovr, ans, low;} msct_row_t;
   logic       clk_in = 1'b0;
   logic       rst_in = 1'b1;
   logic       sel_n  = 1'b0;
   logic       rst_n  = 1'b0;
   logic       lp     = 1'b0;
   logic       ovr    = 1'b0;
   logic [7:0] cond   = 8'h00;
   wire        lclk, stop, is_rd, cor, mwe, pd, pde;
   wire  [7:0] mw;
   logic       ans, lowp, nrdy, int_n, prs;
   logic [7:0] flags, mask;
   int         num_errors = 0;
   int         n_compared = 0;
   msct_row_t  rows [5] = '{'{0,0,0,1,0}, '{1,0,0,0,0}, '{0,1,0,1,1}, '{0,0,1,1,1},
                          '{0,0,0,1,0}};

   always #2.5 clk_in = ~clk_in;

   msct_host_model host_u (.link_clk_out(lclk), .stop_seen_out(stop), .stop_is_read_out(is_rd),
      .cor_access_out(cor), .mask_wr_out(mw), .mask_wr_en_out(mwe), .pdown_wr_out(pd),
      .pdown_wr_en_out(pde));
   msct_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .link_clk_in(lclk),
      .module_select_n(sel_n), .module_reset_n(rst_n), .low_power_pin(lp),
      .stop_seen_in(stop), .stop_is_read_in(is_rd), .cor_access_in(cor), .mask_wr_in(mw),
      .mask_wr_en_in(mwe), .pdown_wr_in(pd), .pdown_wr_en_in(pde), .override_in(ovr),
      .cond_in(cond), .bus_answer_out(ans), .low_power_out(lowp), .not_ready_out(nrdy),
      .flags_out(flags), .mask_out(mask), .interrupt_out_n(int_n), .present_out_n(prs));

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (60000) @(posedge clk_in);
      num_errors++;
      complete_run();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      host_u.tick(4); // link flops need edges while held in reset
      idle(8);
      rst_n  = 1'b1;
      rst_in = 1'b0;
      idle(100);
      check({7'h00, nrdy}, 8'h00);
      check({7'h00, prs}, 8'h00);
      check({7'h00, int_n}, 8'h00);
      host_u.frame(2, 8'h00);
      idle(20);
      check({7'h00, int_n}, 8'h01);
      $display("test init done");
      foreach (rows[i]) begin
         sel_n = rows[i].sel_n;
         lp    = rows[i].lp;
         ovr   = rows[i].ovr;
         idle(60); // host keeps off the bus until the select latency ends
         check({7'h00, ans}, {7'h00, rows[i].ans});
         check({7'h00, lowp}, {7'h00, rows[i].low});
      end
      host_u.frame(2, 8'h00);
      idle(20);
      $display("test table done");
      cond = 8'h01;
      idle(10);
      check(flags, 8'h01);
      check({7'h00, int_n}, 8'h00);
      host_u.frame(0, 8'h01);
      idle(10);
      check(mask, 8'h01);
      check({7'h00, int_n}, 8'h01);
      cond = 8'h00;
      host_u.frame(2, 8'h00);
      idle(10);
      check(flags, 8'h00);
      cond = 8'h01;
      idle(10);
      check({7'h00, int_n}, 8'h01);
      host_u.frame(0, 8'h00);
      idle(10);
      check({7'h00, int_n}, 8'h00);
      cond = 8'h00;
      host_u.frame(2, 8'h00);
      idle(10);
      check({7'h00, int_n}, 8'h01);
      $display("test mask done");
      host_u.frame(1, 8'h01);
      idle(10);
      check({7'h00, lowp}, 8'h01);
      host_u.frame(1, 8'h00);
      idle(60);
      check({7'h00, lowp}, 8'h00);
      check({6'h00, nrdy, int_n}, 8'h00);
      host_u.frame(2, 8'h00);
      $display("test power done");
      host_u.frame(0, 8'h5a);
      idle(10);
      rst_n = 1'b0;
      host_u.tick(4);
      idle(420); // held past the minimum pulse
      check({6'h00, nrdy, int_n}, 8'h03);
      check(mask, 8'h00);
      rst_n = 1'b1;
      idle(100);
      check({7'h00, nrdy}, 8'h00);
      $display("test reset pin done");
      complete_run();
   end
endmodule // testbench
